// ==== inc/blank_pkg.sv ====
// shared constants and types for the blanking evaluator
package blank_pkg;
    localparam int NUM_AREAS = 4;
    localparam int BEAM_W = 8;
    localparam int DEFAULT_BEAMS = 32;
    localparam int SYNC_BEAM = 0;
    localparam int MAX_POS_TOL = 2;
    localparam int MAX_FIXED_SIZE_TOL = 1;
    localparam int MAX_FLOAT_SIZE_TOL = 2;
    localparam int RES_W = 4;
    localparam logic RST_CLEAR = 1'h0;
    localparam logic RST_STOP = 1'h1;
    localparam logic RST_IND = 1'h0;
    localparam logic [NUM_AREAS-1:0] RST_AREA_OK = 4'h0;
    localparam logic [RES_W-1:0] RST_RES = 4'h0;

    typedef enum logic [2:0] {
        AREA_OFF,
        AREA_FIXED,
        AREA_FIXED_INC,
        AREA_FLOAT_FULL,
        AREA_FLOAT_PART
    } area_kind_e;

    typedef struct packed {
        area_kind_e kind;
        logic [BEAM_W-1:0] lo;
        logic [BEAM_W-1:0] hi;
        logic [BEAM_W-1:0] size;
        logic [1:0] pos_tol;
        logic [1:0] size_tol;
        logic inc_up;
        logic [BEAM_W-1:0] inc_len;
    } area_cfg_s;
endpackage

// ==== rtl/beam_area_check.sv ====
// one blanked area: window mask and monitoring verdict
`timescale 1ns/100ps
module beam_area_check
    import blank_pkg::*;
#(
    parameter int NUM_BEAMS = DEFAULT_BEAMS
) (
    input wire area_cfg_s cfg,
    input wire logic fine_res,
    input wire logic [NUM_BEAMS-1:0] blocked,
    output logic [NUM_BEAMS-1:0] excl,
    output logic ok,
    output logic [RES_W-1:0] edge_res
);
    always_comb begin
        int ptol;
        int stol;
        int wlo;
        int whi;
        int cnt;
        int first_b;
        int last_b;
        int need;
        logic core_all;
        logic contig;
        ptol = 0;
        stol = 0;
        wlo = int'(cfg.lo);
        whi = int'(cfg.hi);
        cnt = 0;
        first_b = 0;
        last_b = 0;
        core_all = 1'h1;
        contig = 1'h1;
        need = int'(cfg.hi) - int'(cfg.lo) + 1;
        unique case (cfg.kind)
            AREA_FIXED: begin
                // position tolerance only on fine-pitch units
                if (fine_res) begin
                    ptol = (int'(cfg.pos_tol) > MAX_POS_TOL) ?
                        MAX_POS_TOL : int'(cfg.pos_tol);
                end
                stol = (int'(cfg.size_tol) > MAX_FIXED_SIZE_TOL) ?
                    MAX_FIXED_SIZE_TOL : int'(cfg.size_tol);
                wlo = wlo - ptol;
                whi = whi + ptol;
            end
            AREA_FIXED_INC: begin
                // no other tolerance combines with the widened side
                if (cfg.inc_up) begin
                    whi = whi + int'(cfg.inc_len);
                end else begin
                    wlo = wlo - int'(cfg.inc_len);
                end
            end
            AREA_FLOAT_FULL, AREA_FLOAT_PART: begin
                stol = (int'(cfg.size_tol) > MAX_FLOAT_SIZE_TOL) ?
                    MAX_FLOAT_SIZE_TOL : int'(cfg.size_tol);
                need = int'(cfg.size);
            end
            default: begin
            end
        endcase
        if (wlo <= SYNC_BEAM) begin
            wlo = SYNC_BEAM + 1;
        end
        if (whi > NUM_BEAMS - 1) begin
            whi = NUM_BEAMS - 1;
        end
        for (int i = 0; i < NUM_BEAMS; i++) begin
            excl[i] = (cfg.kind != AREA_OFF) && (i >= wlo) &&
                (i <= whi);
            if (excl[i] && blocked[i]) begin
                if (cnt == 0) begin
                    first_b = i;
                end
                last_b = i;
                cnt = cnt + 1;
            end
            if ((i >= int'(cfg.lo)) && (i <= int'(cfg.hi)) &&
                !blocked[i]) begin
                core_all = 1'h0;
            end
        end
        contig = (cnt == 0) || (last_b - first_b + 1 == cnt);
        unique case (cfg.kind)
            AREA_OFF: ok = 1'h1;
            // no tolerance means exact fit, no movement
            AREA_FIXED: ok = contig && (cnt <= need) &&
                (cnt >= need - stol);
            AREA_FIXED_INC: ok = core_all;
            AREA_FLOAT_FULL: ok = contig && (cnt > 0) && (cnt <= need) &&
                (cnt >= need - stol);
            AREA_FLOAT_PART: ok = contig && (cnt <= need);
            default: ok = 1'h0;
        endcase
        // edge resolution is two beams at the full floating size tolerance of 2, zero for an area that is off, one beam otherwise
        edge_res = (cfg.kind == AREA_OFF) ? '0 :
            ((stol == MAX_FLOAT_SIZE_TOL) ? RES_W'(2) : RES_W'(1));
    end
endmodule

// ==== rtl/beam_blanking_evaluator.sv ====
// protective field evaluation with up to four blanked areas
`timescale 1ns/100ps
module beam_blanking_evaluator
    import blank_pkg::*;
#(
    parameter int NUM_BEAMS = DEFAULT_BEAMS
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic scan_valid,
    input wire logic [NUM_BEAMS-1:0] beam_blocked,
    input wire area_cfg_s area_cfg [NUM_AREAS],
    input wire logic fine_res,
    input wire logic aligned,
    output logic field_clear_reg,
    output logic stop_reg,
    output logic blank_ind_reg,
    output logic [NUM_AREAS-1:0] area_ok_reg,
    output logic [RES_W-1:0] eff_res_reg
);
    logic [NUM_BEAMS-1:0] area_excl [NUM_AREAS];
    logic [RES_W-1:0] area_res [NUM_AREAS];
    logic [NUM_AREAS-1:0] area_ok_w;
    logic [NUM_BEAMS-1:0] excl_all;
    logic [NUM_BEAMS-1:0] free_hit;
    logic field_ok_w;
    logic any_fixed;
    logic [RES_W-1:0] res_w;
    logic field_clear_next;
    logic blank_ind_next;

    function automatic logic is_fixed(input area_kind_e k);
        return (k == AREA_FIXED) || (k == AREA_FIXED_INC);
    endfunction

    genvar g;
    generate
        for (g = 0; g < NUM_AREAS; g++) begin : g_area
            beam_area_check #(
                .NUM_BEAMS(NUM_BEAMS)
            ) u_area (
                .cfg(area_cfg[g]),
                .fine_res(fine_res),
                .blocked(beam_blocked),
                .excl(area_excl[g]),
                .ok(area_ok_w[g]),
                .edge_res(area_res[g])
            );
        end
    endgenerate

    // masks are ored, so overlapping areas need no spacing here
    always_comb begin
        logic [NUM_BEAMS-1:0] m;
        m = '0;
        for (int a = 0; a < NUM_AREAS; a++) begin
            m = m | area_excl[a];
        end
        m[SYNC_BEAM] = 1'h0;
        excl_all = m;
    end

    always_comb begin
        logic [RES_W-1:0] r;
        logic f;
        r = '0;
        f = 1'h0;
        for (int a = 0; a < NUM_AREAS; a++) begin
            f = f | is_fixed(area_cfg[a].kind);
            if (area_res[a] > r) begin
                r = area_res[a];
            end
            for (int b = 0; b < NUM_AREAS; b++) begin
                if ((area_cfg[a].kind == AREA_FLOAT_PART) &&
                    is_fixed(area_cfg[b].kind) &&
                    (|(area_excl[a] & area_excl[b])) &&
                    (RES_W'(area_res[a] + area_res[b]) > r)) begin
                    r = RES_W'(area_res[a] + area_res[b]);
                end
            end
        end
        res_w = r;
        any_fixed = f;
    end

    assign free_hit = beam_blocked & ~excl_all;
    assign field_ok_w = !(|free_hit) && (&area_ok_w);
    assign field_clear_next = scan_valid ? field_ok_w : field_clear_reg;
    assign blank_ind_next = aligned && any_fixed;

    // verdict only moves on a scan, so it never glitches mid-scan
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            field_clear_reg <= RST_CLEAR;
            stop_reg <= RST_STOP;
            area_ok_reg <= RST_AREA_OK;
            eff_res_reg <= RST_RES;
        end else if (scan_valid) begin
            field_clear_reg <= field_clear_next;
            stop_reg <= !field_clear_next;
            area_ok_reg <= area_ok_w;
            eff_res_reg <= res_w;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            blank_ind_reg <= RST_IND;
        end else begin
            blank_ind_reg <= blank_ind_next;
        end
    end

    sequence scan_with_free_hit;
        scan_valid && (|free_hit);
    endsequence

    sequence scan_with_bad_area;
        scan_valid && !(&area_ok_w);
    endsequence

    // only blanked beams hit, every area content
    sequence blanked_only;
        scan_valid && (|(beam_blocked & excl_all)) && !(|free_hit) &&
            (&area_ok_w);
    endsequence

    // partial floating area laid over a fixed one
    sequence part_on_fixed;
        scan_valid && (area_cfg[2].kind == AREA_FLOAT_PART) &&
            (area_cfg[0].kind == AREA_FIXED) &&
            (|(area_excl[2] & area_excl[0]));
    endsequence

    clear_vs_stop_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        field_clear_reg != stop_reg)
        else $error("clear and stop disagree");

    free_beam_stop_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        scan_with_free_hit |=> stop_reg && !field_clear_reg)
        else $error("free beam hit did not stop");

    area_fail_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        scan_with_bad_area |=> stop_reg)
        else $error("failed area did not stop");

    clear_scan_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        scan_valid && field_ok_w |=> field_clear_reg)
        else $error("clean scan not reported clear");

    verdict_hold_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        !scan_valid |=> $stable(field_clear_reg) && $stable(stop_reg))
        else $error("verdict changed without scan");

    sync_beam_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        !excl_all[SYNC_BEAM])
        else $error("synchronising beam blanked");

    sync_hit_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        scan_valid && beam_blocked[SYNC_BEAM] |=> stop_reg)
        else $error("first beam hit did not stop");

    blank_ind_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        blank_ind_reg == $past(aligned && any_fixed))
        else $error("blanking indicator wrong");

    edge_res_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        scan_valid && (area_cfg[0].kind != AREA_OFF) |=> eff_res_reg != 0)
        else $error("no edge resolution with area on");

    area_hold_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        !scan_valid |=> $stable(area_ok_reg) && $stable(eff_res_reg))
        else $error("area verdict changed without scan");

    area_load_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        scan_valid |=> area_ok_reg == $past(area_ok_w))
        else $error("area verdicts not taken on scan");

    blanked_pass_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        blanked_only |=> field_clear_reg && !stop_reg)
        else $error("blanked beam hit stopped the field");

    no_fixed_ind_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        !any_fixed |=> !blank_ind_reg)
        else $error("indicator lit without fixed area");

    overlap_res_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        part_on_fixed |=>
            eff_res_reg >= $past(RES_W'(area_res[0] + area_res[2])))
        else $error("overlap resolution not summed");

    res_load_a: assert property (
        @(posedge sys_clk) disable iff (rst)
        scan_valid |=> eff_res_reg == $past(res_w))
        else $error("edge resolution not taken on scan");
endmodule

// ==== verif/beam_front_end.sv ====
// scan front end model: one-cycle scan pulse per request
`timescale 1ns/100ps
module beam_front_end
    import blank_pkg::*;
#(
    parameter int NUM_BEAMS = DEFAULT_BEAMS
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic req,
    input wire logic [NUM_BEAMS-1:0] pattern,
    output logic scan_valid,
    output logic [NUM_BEAMS-1:0] beam_blocked
);
    // lines toggle between scans so a stale sample cannot pass
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            scan_valid <= 1'h0;
            beam_blocked <= {NUM_BEAMS{1'h1}};
        end else if (req) begin
            scan_valid <= 1'h1;
            beam_blocked <= pattern;
        end else begin
            scan_valid <= 1'h0;
            beam_blocked <= ~beam_blocked;
        end
    end
endmodule

// ==== verif/beam_blanking_evaluator_tb.sv ====
// self-checking bench for the blanking evaluator
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t value mismatch", $time); end end
module beam_blanking_evaluator_tb
    import blank_pkg::*;
;
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    logic req = 1'h0;
    logic fine_res = 1'h0;
    logic aligned = 1'h0;
    logic [31:0] pattern = 32'h0;
    area_cfg_s area_cfg [NUM_AREAS];
    logic scan_valid;
    logic [31:0] beam_blocked;
    logic field_clear_reg, stop_reg, blank_ind_reg;
    logic [NUM_AREAS-1:0] area_ok_reg;
    logic [RES_W-1:0] eff_res_reg;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;

    always #2 sys_clk = ~sys_clk;

    beam_front_end beam_front_end_inst (.sys_clk, .rst, .req, .pattern,
        .scan_valid, .beam_blocked);
    beam_blanking_evaluator beam_blanking_evaluator_inst (.sys_clk, .rst,
        .scan_valid, .beam_blocked, .area_cfg, .fine_res, .aligned,
        .field_clear_reg, .stop_reg, .blank_ind_reg, .area_ok_reg,
        .eff_res_reg);

    function automatic area_cfg_s mk(area_kind_e k, logic [7:0] lo, hi,
                                     sz, logic [1:0] st);
        return '{k, lo, hi, sz, 2'h0, st, 1'h0, 8'h00};
    endfunction

    task automatic complete_run();
        if (err_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // one scan, verdict looked at 1 ns after the taking edge
    task automatic scan(logic [31:0] p, logic c, logic [3:0] ok);
        @(posedge sys_clk);
        req <= 1'h1;
        pattern <= p;
        @(posedge sys_clk);
        req <= 1'h0;
        @(posedge sys_clk);
        #1;
        `CHK(field_clear_reg, c)
        `CHK(stop_reg, ~c)
        `CHK(area_ok_reg, ok)
    endtask

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            complete_run();
        end
    end

    initial begin
        foreach (area_cfg[i]) area_cfg[i] = '0;
        repeat (8) @(posedge sys_clk);
        `CHK(stop_reg, 1'h1)
        `CHK(field_clear_reg, 1'h0)
        rst <= 1'h0;
        // at least one free beam between areas, inc region off the last beam
        area_cfg[0] <= mk(AREA_FIXED, 8'h04, 8'h06, 8'h03, 2'h0);
        area_cfg[1] <= mk(AREA_FLOAT_FULL, 8'h0A, 8'h11, 8'h03, 2'h1);
        area_cfg[2] <= mk(AREA_FLOAT_PART, 8'h14, 8'h17, 8'h03, 2'h0);
        // widened by two beams below, one assignment per step
        area_cfg[3] <= '{AREA_FIXED_INC, 8'h1B, 8'h1C, 8'h02, 2'h0, 2'h0,
            1'h0, 8'h02};
        scan(32'h18003870, 1'h1, 4'hF);
        `CHK(eff_res_reg, 4'h1)
        scan(32'h18003850, 1'h0, 4'hE);
        scan(32'h18003871, 1'h0, 4'hF);
        scan(32'h18003970, 1'h0, 4'hF);
        scan(32'h18000070, 1'h0, 4'hD);
        scan(32'h18001870, 1'h1, 4'hF);
        scan(32'h18000870, 1'h0, 4'hD);
        scan(32'h18303870, 1'h1, 4'hF);
        scan(32'h18F03870, 1'h0, 4'hB);
        scan(32'h1E003870, 1'h1, 4'hF);
        scan(32'h08003870, 1'h0, 4'h7);
        @(posedge sys_clk);
        area_cfg[0].size_tol <= 2'h1;
        scan(32'h18003830, 1'h1, 4'hF);
        scan(32'h18003810, 1'h0, 4'hE);
        @(posedge sys_clk);
        area_cfg[0].size_tol <= 2'h0;
        area_cfg[0].pos_tol <= 2'h2;
        fine_res <= 1'h1;
        scan(32'h180039C0, 1'h1, 4'hF);
        `CHK(eff_res_reg, 4'h1)
        @(posedge sys_clk);
        fine_res <= 1'h0;
        scan(32'h180039C0, 1'h0, 4'hE);
        @(posedge sys_clk);
        area_cfg[0].pos_tol <= 2'h0;
        area_cfg[1].size_tol <= 2'h2;
        scan(32'h18003870, 1'h1, 4'hF);
        `CHK(eff_res_reg, 4'h2)
        @(posedge sys_clk);
        area_cfg[1].size_tol <= 2'h1;
        area_cfg[2].lo <= 8'h03;
        area_cfg[2].hi <= 8'h08;
        scan(32'h18003870, 1'h1, 4'hF);
        `CHK(eff_res_reg, 4'h2)
        @(posedge sys_clk);
        aligned <= 1'h1;
        repeat (2) @(posedge sys_clk);
        #1;
        `CHK(blank_ind_reg, 1'h1)
        @(posedge sys_clk);
        aligned <= 1'h0;
        repeat (2) @(posedge sys_clk);
        #1;
        `CHK(blank_ind_reg, 1'h0)
        complete_run();
    end
endmodule
